// file: core/cfg_loader.sv
// Passive serial configuration loader with AXI4-Lite control
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
// How it works
// - Host keeps clocking until done rises; device accepts bits until its count reaches length.
// - Cable loading ignores the user start-up clock option entirely.
// - Request, status, bit clock, data and done are shared chain-wide.
// - Wired done lines make all chained devices enter user mode together.
// - Any device seeing status low halts the whole chain's configuration.
// - Fast parallel mode takes a whole byte per bit-clock cycle.
// - Request low in user mode restarts; user mode leaves lines high.
// - Data is sampled on the bit-clock rising edge.
module cfg_loader
  import cfg_pkg::*;
#(
  parameter int STATUS_HOLD_CYCLES = cfg_pkg::STATUS_LOW_CYC,
  parameter int INIT_CLOCKS        = cfg_pkg::INIT_USER_CLOCKS
) (
  input  wire logic        I_MCLK,
  input  wire logic        I_RST_N,
  input  wire logic [7:0]  I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  input  wire logic [7:0]  I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  input  wire logic        I_CFG_REQ_N,
  input  wire logic        I_STATUS_N,
  output logic             O_STATUS_N,
  output logic             O_STATUS_N_OE,
  input  wire logic        I_DONE,
  output logic             O_DONE,
  output logic             O_DONE_OE,
  input  wire logic        I_BIT_CLOCK,
  input  wire logic [7:0]  I_DATA,
  input  wire logic        I_USER_STARTUP_CLOCK,
  output logic [7:0]       O_BYTE,
  output logic             O_BYTE_VALID,
  output logic             O_USER_MODE
);
  import cfg_pkg::*;

  // Register address in word units; low two bits are ignored
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[7:2] <= OFS_BYTE[7:2]);
  endfunction : mapped

  // Byte-lane merge for writable registers
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    for (int i = 0; i < 4; i++) begin
      old_v[8*i +: 8] = strb[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
    end
    merge = old_v;
  endfunction : merge

  logic [12:0]       pins_s;
  logic [7:0]        data_s;
  logic              bclk_s, req_n_s, status_s, done_s, uclk_s;
  logic              bclk_q, uclk_q, bclk_rise, bclk_fall, uclk_rise;
  state_e            state, next_state;
  logic [CTRL_W-1:0] ctrl;
  logic [31:0]       length, count, next_count;
  logic [7:0]        expect_sum, sum, shreg, new_byte;
  logic [2:0]        bitpos;
  logic [15:0]       hold_cnt;
  logic [1:0]        fall_cnt;
  logic [11:0]       uclk_cnt;
  logic              loaded, next_loaded, err, load_edge, byte_done;
  logic              finish, bad, need_uclk, init_ok;
  logic              aw_got, w_got, commit;
  logic [7:0]        aw_addr;
  logic [31:0]       w_data, rd_mux;
  logic [3:0]        w_strb;

  // All pins are outside the clock domain
  cfg_sync #(.WIDTH(13)) u_sync (
    .i_clk   (I_MCLK),
    .i_rst_n (I_RST_N),
    .i_async ({I_USER_STARTUP_CLOCK, I_DONE, I_STATUS_N, I_CFG_REQ_N,
               I_BIT_CLOCK, I_DATA}),
    .o_sync  (pins_s)
  );
  assign data_s   = pins_s[7:0];
  assign bclk_s   = pins_s[8];
  assign req_n_s  = pins_s[9];
  assign status_s = pins_s[10];
  assign done_s   = pins_s[11];
  assign uclk_s   = pins_s[12];

  // Edge finders on the synchronised clocks
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      bclk_q <= 1'b0;
      uclk_q <= 1'b0;
    end else begin
      bclk_q <= bclk_s;
      uclk_q <= uclk_s;
    end
  end
  assign bclk_rise = bclk_s & ~bclk_q;
  assign bclk_fall = ~bclk_s & bclk_q;
  assign uclk_rise = uclk_s & ~uclk_q;

  // Data and clock share one sync delay, so setup at the pin carries over
  assign load_edge  = (state == ST_LOAD) && !loaded && bclk_rise;
  assign byte_done  = load_edge && (ctrl[CTRL_FAST] || bitpos == 3'h7);
  assign new_byte   = ctrl[CTRL_FAST] ? data_s
                    : {data_s[0], shreg[7:1]};
  assign next_count = count + (ctrl[CTRL_FAST] ? 32'h8 : 32'h1);
  assign finish     = load_edge && (next_count >= length);
  // Checksum covers whole bytes only
  assign bad = finish && ctrl[CTRL_CHECK] &&
               ((byte_done ? sum + new_byte : sum) != expect_sum);
  assign next_loaded = (state == ST_CLEAR) ? 1'b0 : (loaded | finish);
  // Cable loading disables the user start-up clock option
  assign need_uclk = ctrl[CTRL_USRCK] && !ctrl[CTRL_CABLE];
  assign init_ok   = (fall_cnt == 2'(INIT_FALL_EDGES)) &&
                     (!need_uclk || uclk_cnt == 12'(INIT_CLOCKS));

  // Sequence from request through load and start-up to user mode
  always_comb begin
    next_state = state;
    case (state)
      ST_CLEAR: begin
        if (req_n_s && hold_cnt == 16'h0 && status_s && !O_STATUS_N_OE) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (!status_s || bad) begin
          next_state = ST_ERROR;
        end else if (loaded && done_s) begin
          next_state = ST_INIT;
        end
      end
      ST_INIT: begin
        if (!status_s) begin
          next_state = ST_ERROR;
        end else if (init_ok) begin
          next_state = ST_USER;
        end
      end
      ST_USER:  next_state = ST_USER;
      ST_ERROR: next_state = ST_ERROR;
      default:  next_state = ST_CLEAR;
    endcase
    if (!req_n_s) begin
      next_state = ST_CLEAR;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      state <= ST_CLEAR;
    end else begin
      state <= next_state;
    end
  end

  // Status hold time after a request or power-up
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N || !req_n_s) begin
      hold_cnt <= 16'(STATUS_HOLD_CYCLES);
    end else if (state == ST_CLEAR && hold_cnt != 16'h0) begin
      hold_cnt <= hold_cnt - 16'h1;
    end
  end

  // Shift path, byte assembly and checksum
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N || state == ST_CLEAR) begin
      count        <= 32'h0;
      shreg        <= 8'h00;
      bitpos       <= 3'h0;
      sum          <= 8'h00;
      O_BYTE_VALID <= 1'b0;
      if (!I_RST_N) begin
        O_BYTE <= 8'h00;
      end
    end else begin
      O_BYTE_VALID <= byte_done;
      if (load_edge) begin
        count  <= next_count;
        shreg  <= new_byte;
        bitpos <= bitpos + 3'h1;
      end
      if (byte_done) begin
        O_BYTE <= new_byte;
        sum    <= sum + new_byte;
      end
    end
  end

  // Load completion and error flag
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      loaded <= 1'b0;
      err    <= 1'b0;
    end else begin
      loaded <= next_loaded;
      if (next_state == ST_ERROR) begin
        err <= 1'b1;
      end else if (state == ST_CLEAR) begin
        err <= 1'b0;
      end
    end
  end

  // Start-up counting: two bit-clock falls, then user clock if enabled
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N || state != ST_INIT) begin
      fall_cnt <= 2'h0;
      uclk_cnt <= 12'h0;
    end else if (fall_cnt != 2'(INIT_FALL_EDGES)) begin
      if (bclk_fall) begin
        fall_cnt <= fall_cnt + 2'h1;
      end
    end else if (need_uclk && uclk_rise && uclk_cnt != 12'(INIT_CLOCKS)) begin
      uclk_cnt <= uclk_cnt + 12'h1;
    end
  end

  // Open-drain pins only ever pull low; the chain shares them
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_STATUS_N    <= 1'b0;
      O_DONE        <= 1'b0;
      O_STATUS_N_OE <= 1'b1;
      O_DONE_OE     <= 1'b1;
      O_USER_MODE   <= 1'b0;
    end else begin
      O_STATUS_N    <= 1'b0;
      O_DONE        <= 1'b0;
      O_STATUS_N_OE <= (next_state == ST_ERROR) ||
                       (next_state == ST_CLEAR &&
                        (!req_n_s || hold_cnt > 16'h1));
      O_DONE_OE     <= !(next_state == ST_INIT || next_state == ST_USER ||
                         (next_state == ST_LOAD && next_loaded));
      O_USER_MODE   <= (next_state == ST_USER);
    end
  end

  // Write channel: address and data taken in either order
  assign commit = aw_got && w_got && !O_BVALID;
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_AWREADY <= 1'b0;
      O_WREADY  <= 1'b0;
      aw_got    <= 1'b0;
      w_got     <= 1'b0;
      aw_addr   <= 8'h00;
      w_data    <= 32'h0;
      w_strb    <= 4'h0;
      O_BVALID  <= 1'b0;
      O_BRESP   <= RESP_OKAY;
    end else begin
      O_AWREADY <= I_AWVALID && !O_AWREADY && !aw_got && !O_BVALID;
      O_WREADY  <= I_WVALID && !O_WREADY && !w_got && !O_BVALID;
      if (I_AWVALID && O_AWREADY) begin
        aw_got  <= 1'b1;
        aw_addr <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_got  <= 1'b1;
        w_data <= I_WDATA;
        w_strb <= I_WSTRB;
      end
      if (commit) begin
        aw_got   <= 1'b0;
        w_got    <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  // Writable registers; status and count ignore writes
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      ctrl       <= CTRL_RST;
      length     <= LENGTH_RST;
      expect_sum <= EXPECT_RST;
    end else if (commit) begin
      case ({aw_addr[7:2], 2'b00})
        OFS_CTRL:
          ctrl <= CTRL_W'(merge(32'(ctrl), w_data, w_strb));
        OFS_LENGTH: length <= merge(length, w_data, w_strb);
        OFS_EXPECT:
          expect_sum <= 8'(merge(32'(expect_sum), w_data, w_strb));
        default: ;
      endcase
    end
  end

  // Read decode
  always_comb begin
    rd_mux = 32'h0;
    case ({I_ARADDR[7:2], 2'b00})
      OFS_CTRL:   rd_mux = 32'(ctrl);
      OFS_LENGTH: rd_mux = length;
      OFS_EXPECT: rd_mux = 32'(expect_sum);
      OFS_STATUS: begin
        rd_mux[STAT_STATE +: 5] = state;
        rd_mux[STAT_ERR]        = err;
        rd_mux[STAT_LOADED]     = loaded;
        rd_mux[STAT_USER]       = O_USER_MODE;
        rd_mux[STAT_STPIN]      = status_s;
        rd_mux[STAT_DNPIN]      = done_s;
      end
      OFS_COUNT:  rd_mux = count;
      OFS_BYTE:   rd_mux = 32'(O_BYTE);
      default:    rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h0;
      O_RRESP   <= RESP_OKAY;
    end else begin
      O_ARREADY <= I_ARVALID && !O_ARREADY && !O_RVALID;
      if (I_ARVALID && O_ARREADY) begin
        O_RVALID <= 1'b1;
        O_RDATA  <= rd_mux;
        O_RRESP  <= mapped(I_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      end else if (I_RREADY) begin
        O_RVALID <= 1'b0;
      end
    end
  end

  // Checks
  restart_req_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    !req_n_s |=> state == ST_CLEAR && !O_USER_MODE)
    else $error("request low did not restart");
  status_err_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    (state == ST_LOAD && bad && req_n_s) |=> O_STATUS_N_OE [*2])
    else $error("error not driven on status");
  chain_halt_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    (state == ST_LOAD && !status_s && req_n_s) |=> state == ST_ERROR)
    else $error("status low did not halt load");
  done_wait_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    (state == ST_LOAD ##1 state == ST_INIT) |-> $past(done_s))
    else $error("start-up before shared done high");
  bit_step_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    (load_edge && !ctrl[CTRL_FAST] && req_n_s)
      |=> count == $past(count) + 32'h1)
    else $error("serial bit not counted");
  byte_step_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    (load_edge && ctrl[CTRL_FAST] && req_n_s)
      |=> O_BYTE_VALID && O_BYTE == $past(data_s))
    else $error("parallel byte not taken");
  cable_skip_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    (state == ST_INIT && fall_cnt == 2'(INIT_FALL_EDGES) && ctrl[CTRL_CABLE]
      && req_n_s && status_s) |=> state == ST_USER)
    else $error("cable start-up waited for user clock");
  accept_done_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    (state == ST_LOAD && !loaded) |-> O_DONE_OE)
    else $error("done released before load complete");
  shared_pins_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
    O_USER_MODE |-> !O_STATUS_N_OE && !O_DONE_OE && !O_STATUS_N && !O_DONE)
    else $error("shared line held low in user mode");
endmodule : cfg_loader
`default_nettype wire

// file: core/cfg_pkg.sv
// Constants and types for the passive serial configuration loader
`default_nettype none
package cfg_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_LENGTH = 8'h04;
  localparam logic [7:0] OFS_EXPECT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_COUNT  = 8'h10;
  localparam logic [7:0] OFS_BYTE   = 8'h14;
  // Control register fields
  localparam int CTRL_FAST  = 0;
  localparam int CTRL_CABLE = 1;
  localparam int CTRL_USRCK = 2;
  localparam int CTRL_CHECK = 3;
  localparam int CTRL_W     = 4;
  // Status register fields
  localparam int STAT_STATE  = 0;
  localparam int STAT_ERR    = 8;
  localparam int STAT_LOADED = 9;
  localparam int STAT_USER   = 10;
  localparam int STAT_STPIN  = 11;
  localparam int STAT_DNPIN  = 12;
  // Reset values
  localparam logic [3:0]  CTRL_RST   = 4'h2;
  localparam logic [31:0] LENGTH_RST = 32'h0000_0100;
  localparam logic [7:0]  EXPECT_RST = 8'h00;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing
  localparam int CLK_PERIOD_NS    = 5;
  localparam int STATUS_LOW_NS    = 45000;
  localparam int STATUS_LOW_CYC   =
    (STATUS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_FALL_EDGES  = 2;
  localparam int INIT_USER_CLOCKS = 3192;
  // Loader states
  typedef enum logic [4:0] {
    ST_CLEAR = 5'h01,
    ST_LOAD  = 5'h02,
    ST_INIT  = 5'h04,
    ST_USER  = 5'h08,
    ST_ERROR = 5'h10
  } state_e;
endpackage : cfg_pkg
`default_nettype wire

// file: core/cfg_sync.sv
// Two-flop synchroniser for a group of pin inputs
`default_nettype none
module cfg_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule : cfg_sync
`default_nettype wire

// file: bench/cfg_host_model.sv
// Behavioural host that drives the configuration link of the loader
`default_nettype none
module cfg_host_model (
  input  wire logic       i_status,
  input  wire logic       i_done,
  output logic            o_bit_clock,
  output logic [7:0]      o_data,
  output logic            o_cfg_req_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // Clock parked low between frames
  initial begin
    o_bit_clock = 1'b0;
    o_data      = 8'h00;
    o_cfg_req_n = 1'b1;
  end

  // Restart pulse, 600 ns of request low; the bench calls it after errors
  task automatic restart();
    o_cfg_req_n = 1'b0;
    #600;
    o_cfg_req_n = 1'b1;
  endtask : restart

  // One 48 ns cycle, data stable well around the rise
  task automatic clock_word(input logic [7:0] d);
    o_data = d;
    #12;
    o_bit_clock = 1'b1;
    #24;
    o_bit_clock = 1'b0;
    #12;
    o_data = ~d; // Released data shows no stale value
  endtask : clock_word

  // Frame: wait status high plus 2 us, then bits until done
  task automatic send(input logic [7:0] q[$], input logic fast);
    wait (i_status === 1'b1);
    #2000;
    foreach (q[i]) begin
      if (fast) begin
        if (i_done !== 1'b1) clock_word(q[i]);
      end else begin
        for (int k = 0; k < 8; k++) begin
          // Bit on line 0, other lines toggle to catch misuse
          if (i_done !== 1'b1) clock_word({{7{~q[i][k]}}, q[i][k]});
        end
      end
    end
    // Trailing falling edges for initialization
    repeat (3) clock_word(o_data);
  endtask : send
endmodule : cfg_host_model
`default_nettype wire

// file: bench/passive_serial_config_loader_tb_top.sv
// Self-checking testbench for the configuration loader
`default_nettype none
module passive_serial_config_loader_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cfg_pkg::*;

  logic I_MCLK = 1'b0;
  logic I_RST_N = 1'b0;
  logic [7:0] awaddr, araddr, o_byte, host_data;
  logic [31:0] wdata, rdata, o_rdata;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready, chain_err, usr_clk;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, status_oe;
  logic done_oe, byte_valid, user_mode, bit_clock, req_n;
  logic st_o, dn_o;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] sent[$], got[$];
  int n_mismatch = 0;
  int num_checks = 0;
  // Open-drain wires with pull-ups; chain partner may pull status
  wire status_w = (status_oe ? st_o : 1'b1) && !chain_err;
  wire done_w = done_oe ? dn_o : 1'b1;

  always #2.5 I_MCLK = ~I_MCLK;

  cfg_loader #(.STATUS_HOLD_CYCLES(20), .INIT_CLOCKS(8)) i_cfg_loader (
    .I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_AWADDR(awaddr),
    .I_AWVALID(awvalid), .O_AWREADY(o_awready), .I_WDATA(wdata),
    .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(o_wready),
    .O_BRESP(bresp), .O_BVALID(o_bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(o_arready),
    .O_RDATA(o_rdata), .O_RRESP(rresp), .O_RVALID(o_rvalid),
    .I_RREADY(rready), .I_CFG_REQ_N(req_n), .I_STATUS_N(status_w),
    .O_STATUS_N(st_o), .O_STATUS_N_OE(status_oe), .I_DONE(done_w),
    .O_DONE(dn_o), .O_DONE_OE(done_oe), .I_BIT_CLOCK(bit_clock),
    .I_DATA(host_data), .I_USER_STARTUP_CLOCK(usr_clk), .O_BYTE(o_byte),
    .O_BYTE_VALID(byte_valid), .O_USER_MODE(user_mode));

  cfg_host_model i_cfg_host_model (.i_status(status_w), .i_done(done_w),
    .o_bit_clock(bit_clock), .o_data(host_data), .o_cfg_req_n(req_n));

  // Collect every assembled byte
  always @(posedge I_MCLK) if (byte_valid === 1'b1) got.push_back(o_byte);

  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Write: address and data offered together, wait for response
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge I_MCLK);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge I_MCLK);
      if (o_awready) awvalid <= 1'b0;
      if (o_wready) wvalid <= 1'b0;
    end while (o_bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge I_MCLK);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge I_MCLK);
      if (o_arready) arvalid <= 1'b0;
    end while (o_rvalid !== 1'b1);
    rdata = o_rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // Modulo-256 sum of whole bytes, as the loader checks it
  function automatic logic [7:0] byte_sum(input logic [7:0] q[$]);
    byte_sum = 8'h00;
    foreach (q[i]) byte_sum += q[i];
  endfunction : byte_sum

  // Random frame through the host model, bytes compared after
  task automatic load(input int n, input logic fast, input logic corrupt);
    sent.delete();
    got.delete();
    repeat (n) sent.push_back(8'($urandom));
    // A corrupted sum must be refused at the end of the load
    axi_wr(OFS_EXPECT, {24'h0, byte_sum(sent) ^ {7'h00, corrupt}});
    i_cfg_host_model.restart();
    i_cfg_host_model.send(sent, fast);
  endtask : load

  task automatic wait_user();
    for (int t = 0; t < 4000 && user_mode !== 1'b1; t++) @(posedge I_MCLK);
  endtask : wait_user

  task automatic check_frame(input logic [31:0] bits);
    check("byte count", got.size(), sent.size());
    foreach (sent[i]) if (i < got.size()) check("byte", got[i], sent[i]);
    axi_rd(OFS_COUNT);
    check("bit count", rdata, bits);
  endtask : check_frame

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // Watchdog sized well past the whole sequence
  initial begin
    #400000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
    {arvalid, rready, chain_err, usr_clk} = '0;
    wstrb = 4'hF;
    void'($urandom(32'h33AB7B43));
    repeat (4) @(posedge I_MCLK);
    I_RST_N <= 1'b1;
    // Reset values and unmapped place
    axi_rd(OFS_CTRL);
    check("ctrl reset", rdata, {28'h0, CTRL_RST});
    axi_rd(OFS_LENGTH);
    check("length reset", rdata, LENGTH_RST);
    axi_rd(8'h18);
    check("unmapped read", {rdata[29:0], resp}, {30'h0, RESP_SLVERR});
    axi_wr(8'h18, 32'hFFFF_FFFF);
    check("unmapped write", resp, RESP_SLVERR);
    $display("Test registers done");
    // Cable serial load, user clock option set but no clock given
    axi_wr(OFS_CTRL, 32'h0000_0006);
    axi_wr(OFS_LENGTH, 32'h0000_0010);
    load(2, 1'b0, 1'b0);
    wait_user();
    check("user mode", user_mode, 1'b1);
    check_frame(32'h10);
    axi_rd(OFS_STATUS);
    check("state user", rdata[4:0], 5'h08);
    check("done released", done_oe, 1'b0);
    i_cfg_host_model.restart();
    check("user left", user_mode, 1'b0);
    check("status pulled", status_oe, 1'b1);
    $display("Test serial done");
    // Fast parallel: one byte per bit-clock cycle
    axi_wr(OFS_CTRL, 32'h0000_0003);
    axi_wr(OFS_LENGTH, 32'h0000_0020);
    load(4, 1'b1, 1'b0);
    wait_user();
    check("fast user", user_mode, 1'b1);
    check_frame(32'h20);
    $display("Test fast done");
    // Plain load with user clock option and checksum: start-up needs clock
    axi_wr(OFS_CTRL, 32'h0000_000C);
    axi_wr(OFS_LENGTH, 32'h0000_0010);
    load(2, 1'b0, 1'b0);
    repeat (50) @(posedge I_MCLK);
    check("user clock wait", user_mode, 1'b0);
    repeat (20) begin
      repeat (3) @(posedge I_MCLK);
      usr_clk <= ~usr_clk;
    end
    wait_user();
    check("user clock run", user_mode, 1'b1);
    check_frame(32'h10);
    $display("Test user clock done");
    // Wrong checksum: device pulls the shared status line itself
    axi_wr(OFS_CTRL, 32'h0000_000A);
    load(2, 1'b0, 1'b1);
    repeat (10) @(posedge I_MCLK);
    check("sum error", status_oe, 1'b1);
    check("status pin", st_o, 1'b0);
    axi_rd(OFS_STATUS);
    check("sum state", {rdata[STAT_ERR], rdata[4:0]}, 6'h30);
    $display("Test checksum done");
    // Chain partner flags error after the frame, with the load still short of length
    axi_wr(OFS_CTRL, 32'h0000_0002);
    axi_wr(OFS_LENGTH, 32'h0000_0040);
    load(2, 1'b0, 1'b0);
    chain_err <= 1'b1;
    repeat (10) @(posedge I_MCLK);
    chain_err <= 1'b0;
    repeat (10) @(posedge I_MCLK);
    check("error hold", status_oe, 1'b1);
    axi_rd(OFS_STATUS);
    check("error state", {rdata[STAT_ERR], rdata[4:0]}, 6'h30);
    i_cfg_host_model.restart();
    repeat (40) @(posedge I_MCLK);
    check("recovered", status_oe, 1'b0);
    $display("Test chain error done");
    print_verdict();
  end
endmodule : passive_serial_config_loader_tb_top
`default_nettype wire
